// ### fp_round_except_map.vh
// Register offsets, field positions and reset values of the rounding and exception unit
`ifndef FP_ROUND_EXCEPT_MAP_VH
`define FP_ROUND_EXCEPT_MAP_VH

// Register byte offsets
`define REG_CTRL      8'h00
`define REG_OPA_LO    8'h04
`define REG_OPA_HI    8'h08
`define REG_OPB_LO    8'h0C
`define REG_OPB_HI    8'h10
`define REG_RAW_EXP   8'h14
`define REG_RESULT_LO 8'h18
`define REG_RESULT_HI 8'h1C
`define REG_STATUS    8'h20
`define REG_FLAGS     8'h24
`define REG_ENABLE    8'h28
`define REG_CMD       8'h2C

// Control fields
`define CTRL_RMODE_LSB 0
`define CTRL_RMODE_MSB 1
`define CTRL_DOUBLE    2
`define CTRL_READ_BUS  3
`define CTRL_RESET     4'h0

// Raw exponent register fields
`define RAW_EXP_MSB  12
`define RAW_SIGN_BIT 16

// Rounding mode codes
`define RMODE_NEAREST 2'h0
`define RMODE_ZERO    2'h1
`define RMODE_UP      2'h2
`define RMODE_DOWN    2'h3

// Command codes
`define OP_ROUND 3'h0
`define OP_MUL   3'h1
`define OP_DIV   3'h2
`define OP_ADD   3'h3
`define OP_SUB   3'h4
`define OP_F2I   3'h5
`define OP_STORE 3'h6

// Accumulated flag bit positions
`define FLAG_UNDEF 0
`define FLAG_PREC  1
`define FLAG_OVF   2
`define FLAG_UNF   3
`define FLAG_ZDIV  4
`define FLAG_INVAL 5
`define FLAGS_W    6

// Status fields
`define STAT_BUSY    0
`define STAT_PENDING 1
`define STAT_CLASS_A 8
`define STAT_CLASS_B 16

// Format constants
`define SGL_EXP_MAX  11'h0FF
`define DBL_EXP_MAX  11'h7FF
`define SGL_BIAS     13'h007F
`define DBL_BIAS     13'h03FF

`endif

// ### fp_operand_class.v
// Operand field split and class decode for single and double precision
`timescale 1ns/1ps
module fp_operand_class
(
  // Operand in
  input  wire        i_double,
  input  wire [63:0] i_opnd,
  // Decoded fields and class
  output reg         o_sign,
  output reg  [10:0] o_exp,
  output reg  [51:0] o_frac,
  output reg         o_zero,
  output reg         o_den,
  output reg         o_nrm,
  output reg         o_inf,
  output reg         o_nan
);

  reg exp_ones;

  // Field split, single fraction sits in the low 23 bits
  always @*
  begin
    exp_ones = 1'b0;
    if (i_double)
    begin
      o_sign   = i_opnd[63];
      o_exp    = i_opnd[62:52];
      o_frac   = i_opnd[51:0];
      exp_ones = (i_opnd[62:52] == 11'h7FF);
    end
    else
    begin
      o_sign   = i_opnd[31];
      o_exp    = {3'h0, i_opnd[30:23]};
      o_frac   = {29'h0, i_opnd[22:0]};
      exp_ones = (i_opnd[30:23] == 8'hFF);
    end
    // Exponent 1..254 or 1..2046 is normal
    o_nrm  = (o_exp != 11'h000) && !exp_ones;
    o_inf  = exp_ones && (o_frac == 52'h0);
    o_zero = (o_exp == 11'h000) && (o_frac == 52'h0);
    o_nan  = exp_ones && (o_frac != 52'h0);
    o_den  = (o_exp == 11'h000) && (o_frac != 52'h0);
  end

endmodule // fp_operand_class

// ### fp_round_except.v
// Rounding, special-operand resolution and accumulated exception flags with APB access
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "fp_round_except_map.vh"

// Functional notes
// - Single exponent 1..254 is normalized
// - Double exponent 1..2046 is normalized
// - All-ones exponent, zero fraction is infinity
// - Zero exponent and fraction is signed zero
// - All-ones exponent, nonzero fraction is NaN
// - Zero exponent, nonzero fraction is denormal
// - Nearest mode rounds ties to even
// - Toward-zero mode never grows magnitude
// - Up mode never goes below result
// - Down mode never goes above result
// - Enabled raised flag interrupts the host
// - Non-store opcode on read bus: undefined
// - Lost fraction bits set precision flag
// - Lossy float-to-integer sets precision flag
// - Overflow gives max finite or infinity
// - Float-to-integer out of range flags overflow
// - Tiny nonzero result underflows to zero
// - Normal over zero: zero-divide, signed infinity
// - NaN input or invalid combination flags invalid
// - Invalid result is positive all-ones NaN, except float-to-integer, which gives 32'h8000_0000
// - Denormal operands and unnormalized results flush zero
// - Smallest normal: exponent one, fraction zero
module fp_round_except
(
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rst_b,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // Exception interrupt toward the host
  output reg         o_fp_irq
);

  reg         rst_meta;
  reg         rst_sync;
  reg  [3:0]  ctrl;
  reg  [63:0] opa;
  reg  [63:0] opb;
  reg  [12:0] raw_exp;
  reg         raw_sign;
  reg  [63:0] result;
  reg  [2:0]  op;
  reg         run;
  reg         pending;
  reg  [`FLAGS_W-1:0] flags;
  reg  [`FLAGS_W-1:0] enable;
  reg  [31:0] rd_mux;
  reg         hit;

  wire [1:0]  rmode   = ctrl[`CTRL_RMODE_MSB:`CTRL_RMODE_LSB];
  wire        dbl     = ctrl[`CTRL_DOUBLE];
  wire        access  = i_psel && i_penable;
  wire        wr_fire = access && o_pready && i_pwrite && hit;

  // Operand classes
  wire        sa, sb, a_zero, a_den, a_nrm, a_inf, a_nan;
  wire        b_zero, b_den, b_nrm, b_inf, b_nan;
  wire [10:0] a_exp, b_exp;
  wire [51:0] a_frac, b_frac;

  fp_operand_class u_class_a
  (
    .i_double (dbl),
    .i_opnd   (opa),
    .o_sign   (sa),
    .o_exp    (a_exp),
    .o_frac   (a_frac),
    .o_zero   (a_zero),
    .o_den    (a_den),
    .o_nrm    (a_nrm),
    .o_inf    (a_inf),
    .o_nan    (a_nan)
  );

  fp_operand_class u_class_b
  (
    .i_double (dbl),
    .i_opnd   (opb),
    .o_sign   (sb),
    .o_exp    (b_exp),
    .o_frac   (b_frac),
    .o_zero   (b_zero),
    .o_den    (b_den),
    .o_nrm    (b_nrm),
    .o_inf    (b_inf),
    .o_nan    (b_nan)
  );

  // Denormal operands count as zero
  wire za = a_zero || a_den;
  wire zb = b_zero || b_den;

  // Round-up decision per mode
  function round_inc;
    input [1:0] mode;
    input       s;
    input       lsb;
    input       guard;
    input       sticky;
    begin
      case (mode)
        `RMODE_NEAREST: round_inc = guard && (sticky || lsb);
        `RMODE_ZERO:    round_inc = 1'b0;
        `RMODE_UP:      round_inc = !s && (guard || sticky);
        `RMODE_DOWN:    round_inc = s && (guard || sticky);
        default:        round_inc = 1'b0;
      endcase
    end
  endfunction

  // Assemble a value in the selected format
  function [63:0] pack;
    input        d;
    input        s;
    input [10:0] e;
    input [51:0] f;
    begin
      if (d)
        pack = {s, e, f};
      else
        pack = {32'h0, s, e[7:0], f[22:0]};
    end
  endfunction

  // Reset release through two flops
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Rounding of a raw mantissa (opa, leading one at bit 63) and exponent
  wire [63:0] kept    = dbl ? (opa >> 11) : (opa >> 40);
  wire        guard   = dbl ? opa[10] : opa[39];
  wire        sticky  = dbl ? (|opa[9:0]) : (|opa[38:0]);
  wire        r_inc   = round_inc(rmode, raw_sign, kept[0], guard, sticky);
  wire [53:0] rsum    = kept[53:0] + {53'h0, r_inc};
  wire        carry   = dbl ? rsum[53] : rsum[24];
  wire signed [13:0] radj = $signed({raw_exp[12], raw_exp}) + $signed({13'h0, carry});
  wire [10:0] emax    = dbl ? `DBL_EXP_MAX : `SGL_EXP_MAX;

  reg  [63:0] rnd_res;
  reg  [`FLAGS_W-1:0] rnd_set;
  reg         use_max;

  always @*
  begin
    rnd_set = {`FLAGS_W{1'b0}};
    use_max = raw_sign ? (rmode == `RMODE_UP || rmode == `RMODE_ZERO)
                       : (rmode == `RMODE_DOWN || rmode == `RMODE_ZERO);
    rnd_res = pack(dbl, raw_sign, radj[10:0], rsum[51:0]);
    if (opa == 64'h0)
      rnd_res = pack(dbl, raw_sign, 11'h000, 52'h0);         // exact zero, no flag
    else if (!opa[63])
    begin
      rnd_res = pack(dbl, raw_sign, 11'h000, 52'h0);
      rnd_set[`FLAG_UNF] = 1'b1;
    end
    else
    begin
      rnd_set[`FLAG_PREC] = guard || sticky;
      if (radj >= $signed({3'h0, emax}))
      begin
        rnd_set[`FLAG_OVF]  = 1'b1;
        rnd_set[`FLAG_PREC] = 1'b1;
        if (use_max)
          rnd_res = pack(dbl, raw_sign, emax - 11'h001, {52{1'b1}});
        else
          rnd_res = pack(dbl, raw_sign, emax, 52'h0);
      end
      else if (radj < 14'sh0001)
      begin
        // Below exponent one with zero fraction
        rnd_set[`FLAG_UNF] = 1'b1;
        rnd_res = pack(dbl, raw_sign, 11'h000, 52'h0);
      end
    end
  end

  // Float to signed 32-bit integer from operand A
  wire [12:0] bias    = dbl ? `DBL_BIAS : `SGL_BIAS;
  wire signed [12:0] unb = $signed({2'h0, a_exp}) - $signed(bias);
  wire [63:0] m64     = dbl ? {1'b1, a_frac, 11'h000} : {1'b1, a_frac[22:0], 40'h0};
  wire [5:0]  ish     = 6'd63 - unb[5:0];
  wire [5:0]  rsh     = unb[5:0] + 6'd1;
  wire        u_neg   = unb[12];
  wire [63:0] ipart   = u_neg ? 64'h0 : (m64 >> ish);
  wire [63:0] irem    = m64 << rsh;
  wire        i_guard = u_neg ? (unb == -13'sd1) : irem[63];
  wire        i_stk   = u_neg ? ((unb == -13'sd1) ? (|m64[62:0]) : 1'b1) : (|irem[62:0]);
  wire        i_inc   = round_inc(rmode, sa, ipart[0], i_guard, i_stk);
  wire [32:0] imag    = ipart[32:0] + {32'h0, i_inc};
  wire [32:0] ineg    = 33'h0 - imag;

  reg  [31:0] f2i_res;
  reg  [`FLAGS_W-1:0] f2i_set;

  always @*
  begin
    f2i_set = {`FLAGS_W{1'b0}};
    f2i_res = 32'h0000_0000;
    if (a_nan)
    begin
      f2i_set[`FLAG_INVAL] = 1'b1;
      f2i_res = 32'h8000_0000;
    end
    else if (a_inf || (!za && !u_neg && unb > 13'sd31)
             || (!za && (sa ? (imag > 33'h0_8000_0000) : (imag > 33'h0_7FFF_FFFF))))
    begin
      f2i_set[`FLAG_OVF] = 1'b1;
      f2i_res = 32'h8000_0000;
    end
    else if (!za)
    begin
      f2i_set[`FLAG_PREC] = i_guard || i_stk;
      f2i_res = sa ? ineg[31:0] : imag[31:0];
    end
  end

  // Command execution, one cycle after the command write
  reg  [63:0] next_result;
  reg  [`FLAGS_W-1:0] next_set;
  reg         next_pending;
  reg         sbe;
  reg         sx;
  wire [63:0] qnan = dbl ? 64'h7FFF_FFFF_FFFF_FFFF : 64'h0000_0000_7FFF_FFFF;

  always @*
  begin
    next_result  = result;
    next_set     = {`FLAGS_W{1'b0}};
    next_pending = 1'b0;
    sbe          = sb ^ (op == `OP_SUB);
    sx           = sa ^ sb;
    if (ctrl[`CTRL_READ_BUS] && op != `OP_STORE)
      next_set[`FLAG_UNDEF] = 1'b1;
    else
    begin
      case (op)
        `OP_ROUND:
        begin
          next_result = rnd_res;
          next_set    = rnd_set;
        end
        `OP_MUL:
        begin
          if (a_nan || b_nan || (a_inf && zb) || (b_inf && za))
          begin
            next_set[`FLAG_INVAL] = 1'b1;
            next_result = qnan;
          end
          else if (a_inf || b_inf)
            next_result = pack(dbl, sx, emax, 52'h0);
          else if (za || zb)
            next_result = pack(dbl, sx, 11'h000, 52'h0);
          else
            next_pending = 1'b1;
        end
        `OP_DIV:
        begin
          if (a_nan || b_nan || (za && zb) || (a_inf && b_inf))
          begin
            next_set[`FLAG_INVAL] = 1'b1;
            next_result = qnan;
          end
          else if (a_nrm && zb)
          begin
            next_set[`FLAG_ZDIV] = 1'b1;
            next_result = pack(dbl, sx, emax, 52'h0);
          end
          else if (a_inf)
            next_result = pack(dbl, sx, emax, 52'h0);
          else if (b_inf || za)
            next_result = pack(dbl, sx, 11'h000, 52'h0);
          else
            next_pending = 1'b1;
        end
        `OP_ADD, `OP_SUB:
        begin
          if (a_nan || b_nan || (a_inf && b_inf && sa != sbe))
          begin
            next_set[`FLAG_INVAL] = 1'b1;
            next_result = qnan;
          end
          else if (a_inf)
            next_result = pack(dbl, sa, emax, 52'h0);
          else if (b_inf)
            next_result = pack(dbl, sbe, emax, 52'h0);
          else if (za && zb)
            next_result = pack(dbl, (sa == sbe) ? sa : (rmode == `RMODE_DOWN), 11'h000, 52'h0);
          else if (za)
            next_result = pack(dbl, sbe, b_exp, b_frac);
          else if (zb)
            next_result = pack(dbl, sa, a_exp, a_frac);
          else
            next_pending = 1'b1;
        end
        `OP_F2I:
        begin
          next_result = {32'h0, f2i_res};
          next_set    = f2i_set;
        end
        `OP_STORE:
          next_result = za ? pack(dbl, sa, 11'h000, 52'h0)
                           : pack(dbl, sa, a_exp, a_frac);
        default:
          next_set[`FLAG_UNDEF] = 1'b1;
      endcase
    end
  end

  // Register read decode
  always @*
  begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      `REG_CTRL:      rd_mux = {28'h0, ctrl};
      `REG_OPA_LO:    rd_mux = opa[31:0];
      `REG_OPA_HI:    rd_mux = opa[63:32];
      `REG_OPB_LO:    rd_mux = opb[31:0];
      `REG_OPB_HI:    rd_mux = opb[63:32];
      `REG_RAW_EXP:   rd_mux = {15'h0, raw_sign, 3'h0, raw_exp};
      `REG_RESULT_LO: rd_mux = result[31:0];
      `REG_RESULT_HI: rd_mux = result[63:32];
      `REG_STATUS:    rd_mux = {11'h0, b_nan, b_inf, b_nrm, b_den, b_zero,
                                3'h0, a_nan, a_inf, a_nrm, a_den, a_zero,
                                6'h0, pending, run};
      `REG_FLAGS:     rd_mux = {26'h0, flags};
      `REG_ENABLE:    rd_mux = {26'h0, enable};
      `REG_CMD:       rd_mux = {29'h0, op};
      default:        hit = 1'b0;
    endcase
  end

  // APB: one wait state, read data and error captured on the edge that raises pready
  always @(posedge i_sys_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= access && !o_pready;
      if (access && !o_pready)
      begin
        o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_mux;
        o_pslverr <= !hit;
      end
    end
  end

  // Software registers, command launch and result capture
  always @(posedge i_sys_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      ctrl     <= `CTRL_RESET;
      opa      <= 64'h0;
      opb      <= 64'h0;
      raw_exp  <= 13'h0000;
      raw_sign <= 1'b0;
      enable   <= {`FLAGS_W{1'b0}};
      op       <= `OP_ROUND;
      run      <= 1'b0;
      result   <= 64'h0;
      pending  <= 1'b0;
    end
    else
    begin
      run <= wr_fire && (i_paddr == `REG_CMD);
      if (wr_fire)
      begin
        case (i_paddr)
          `REG_CTRL:    ctrl <= i_pwdata[3:0];
          `REG_OPA_LO:  opa[31:0] <= i_pwdata;
          `REG_OPA_HI:  opa[63:32] <= i_pwdata;
          `REG_OPB_LO:  opb[31:0] <= i_pwdata;
          `REG_OPB_HI:  opb[63:32] <= i_pwdata;
          `REG_RAW_EXP:
          begin
            raw_exp  <= i_pwdata[`RAW_EXP_MSB:0];
            raw_sign <= i_pwdata[`RAW_SIGN_BIT];
          end
          `REG_ENABLE:  enable <= i_pwdata[`FLAGS_W-1:0];
          `REG_CMD:     op <= i_pwdata[2:0];
          default:      op <= op;
        endcase
      end
      if (run)
      begin
        result  <= next_result;
        pending <= next_pending;
      end
    end
  end

  // Sticky flags, write one to clear, a new event wins over its clear
  wire [`FLAGS_W-1:0] clr = (wr_fire && i_paddr == `REG_FLAGS) ?
                            i_pwdata[`FLAGS_W-1:0] : {`FLAGS_W{1'b0}};
  wire [`FLAGS_W-1:0] evt = run ? next_set : {`FLAGS_W{1'b0}};

  always @(posedge i_sys_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      flags    <= {`FLAGS_W{1'b0}};
      o_fp_irq <= 1'b0;
    end
    else
    begin
      flags    <= (flags & ~clr) | evt;
      o_fp_irq <= |(flags & enable);
    end
  end

endmodule // fp_round_except

// ### fp_round_except_assertions.sv
// Concurrent checks on the bus and interrupt ports of the rounding unit
`timescale 1ns/1ps
`include "fp_round_except_map.vh"
module fp_round_except_assertions
(
  // Clock and reset
  input logic        i_sys_clk,
  input logic        i_rst_b,
  // APB slave side
  input logic        i_psel,
  input logic        i_penable,
  input logic        i_pwrite,
  input logic [7:0]  i_paddr,
  input logic [31:0] i_pwdata,
  input logic [31:0] o_prdata,
  input logic        o_pready,
  input logic        o_pslverr,
  // Interrupt
  input logic        o_fp_irq
);
  // Everything samples on the system clock outside reset
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  // Handshake shape
  chk_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready high for more than one cycle");
  chk_ready_timing: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
    else $error("pready not in second access cycle");
  chk_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside an access phase");
  // Address decode and read data
  chk_err_decode: assert property (o_pready
    |-> o_pslverr == (i_paddr > `REG_CMD || i_paddr[1:0] != 2'h0))
    else $error("pslverr does not match address map");
  chk_write_data_zero: assert property (o_pready && i_pwrite |-> o_prdata == 32'h0)
    else $error("prdata not zero on a write");
  chk_flags_width: assert property (o_pready && !i_pwrite && i_paddr == `REG_FLAGS
    |-> o_prdata[31:6] == 26'h0)
    else $error("flags read shows bits above the flag field");
  // Interrupt follows enabled flags
  chk_irq_enable_off: assert property (
    o_pready && i_pwrite && i_paddr == `REG_ENABLE && i_pwdata[5:0] == 6'h00
    |-> ##2 !o_fp_irq)
    else $error("interrupt stays up with all enables off");
  chk_irq_flag_clear: assert property (
    o_pready && i_pwrite && i_paddr == `REG_FLAGS && i_pwdata[5:0] == 6'h3F
    |-> ##2 !o_fp_irq)
    else $error("interrupt stays up after all flags cleared");

  // Main scenarios
  cov_err: cover property (o_pready && o_pslverr);
  cov_cmd: cover property (o_pready && i_pwrite && i_paddr == `REG_CMD);
  cov_irq: cover property ($rose(o_fp_irq));
endmodule // fp_round_except_assertions

// ### fp_host_model.sv
// Host processor model issuing APB transfers to the rounding unit
`timescale 1ns/1ps
module fp_host_model
(
  // Clock
  input  logic        i_sys_clk,
  // APB master side
  output logic        o_psel,
  output logic        o_penable,
  output logic        o_pwrite,
  output logic [7:0]  o_paddr,
  output logic [31:0] o_pwdata,
  input  logic [31:0] i_prdata,
  input  logic        i_pready,
  input  logic        i_pslverr
);
  // Bus idle at time zero
  initial
  begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 8'h00;
    o_pwdata  = 32'h0;
  end

  // One transfer: setup, access until ready, then release with scrambled data
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge i_sys_clk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= wr;
    o_paddr   <= a;
    o_pwdata  <= d;
    @(posedge i_sys_clk);
    o_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (i_pready !== 1'b1)
      @(posedge i_sys_clk);
    rd = i_prdata;
    er = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    o_pwdata  <= ~d;
  endtask
endmodule // fp_host_model

// ### fp_round_except_tb.sv
// Self-checking bench for the rounding and exception unit
`timescale 1ns/1ps
`include "fp_round_except_map.vh"
module fp_round_except_tb;
  // Clock, reset and bus wires
  logic        i_sys_clk;
  logic        i_rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fp_irq;
  logic [31:0] rd;
  logic        er;
  int          error_cnt;
  int          total_checks;

  // Unit under test and host
  fp_round_except dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_fp_irq(fp_irq));
  fp_host_model host (.i_sys_clk(i_sys_clk), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr));

  // 20 MHz clock, reset low at time zero
  initial
  begin
    i_sys_clk = 1'b0;
    i_rst_b   = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // Verdict and end of run
  task automatic finish_test;
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compare and count
  task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Register access helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    host.xfer(1'b0, a, 32'h0, rd, er);
    check(nm, {32'h0, e}, {32'h0, rd});
  endtask

  // Load operands, clear flags, issue a command, check result and flags
  task automatic op(input logic [3:0] c, input logic [63:0] a, input logic [63:0] b,
                    input logic [16:0] r, input logic [2:0] o, input logic [63:0] e,
                    input logic [5:0] f);
    logic [63:0] res;
    wr(`REG_CTRL, {28'h0, c});
    wr(`REG_OPA_LO, a[31:0]);
    wr(`REG_OPA_HI, a[63:32]);
    wr(`REG_OPB_LO, b[31:0]);
    wr(`REG_OPB_HI, b[63:32]);
    wr(`REG_RAW_EXP, {15'h0, r});
    wr(`REG_FLAGS, 32'h0000003F);
    wr(`REG_CMD, {29'h0, o});
    host.xfer(1'b0, `REG_RESULT_LO, 32'h0, res[31:0], er);
    host.xfer(1'b0, `REG_RESULT_HI, 32'h0, res[63:32], er);
    check("result", e, res);
    rdc(`REG_FLAGS, {26'h0, f}, "flags");
  endtask

  // Main sequence
  initial
  begin
    error_cnt    = 0;
    total_checks = 0;
    repeat (16) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rdc(`REG_CTRL, 32'h0, "ctrl reset");
    rdc(`REG_ENABLE, 32'h0, "enable reset");
    host.xfer(1'b0, 8'h30, 32'h0, rd, er);
    check("unmapped", 64'h1, {63'h0, er});
    check("unmapped data", 64'h0, {32'h0, rd});
    // Operand classes through store
    op(4'h0, 32'h80000001, 1'b0, 1'b0, 3'h6, 32'h80000000, 6'h00);
    op(4'h0, 32'h00800000, 1'b0, 1'b0, 3'h6, 32'h00800000, 6'h00);
    op(4'h0, 32'h7F7FFFFF, 1'b0, 1'b0, 3'h6, 32'h7F7FFFFF, 6'h00);
    op(4'h4, 64'h000FFFFFFFFFFFFF, 1'b0, 1'b0, 3'h6, 1'b0, 6'h00);
    op(4'h4, 64'h7FEFFFFFFFFFFFFF, 1'b0, 1'b0, 3'h6, 64'h7FEFFFFFFFFFFFFF, 6'h00);
    // Read-bus operation and undefined opcode
    op(4'h8, 32'h3F800000, 1'b0, 1'b0, 3'h6, 32'h3F800000, 6'h00);
    op(4'h8, 32'h40000000, 1'b0, 1'b0, 3'h1, 32'h3F800000, 6'h01);
    op(4'h0, 32'h3F800000, 1'b0, 1'b0, 3'h7, 32'h3F800000, 6'h01);
    // Special operands
    op(4'h0, 32'h7F800000, 1'b0, 1'b0, 3'h1, 32'h7FFFFFFF, 6'h20);
    op(4'h0, 1'b0, 32'h80000000, 1'b0, 3'h2, 32'h7FFFFFFF, 6'h20);
    op(4'h0, 32'h7F800000, 32'hFF800000, 1'b0, 3'h2, 32'h7FFFFFFF, 6'h20);
    op(4'h0, 32'hFF800000, 32'hFF800000, 1'b0, 3'h4, 32'h7FFFFFFF, 6'h20);
    op(4'h0, 32'h7F800000, 32'hFF800000, 1'b0, 3'h3, 32'h7FFFFFFF, 6'h20);
    op(4'h0, 32'h7FC00000, 32'h3F800000, 1'b0, 3'h1, 32'h7FFFFFFF, 6'h20);
    rdc(`REG_STATUS, 32'h00041000, "status nan");
    // Two normal operands: arithmetic left pending, result untouched; then infinity and denormal cases
    op(4'h0, 32'h3F800000, 32'h40000000, 1'b0, 3'h1, 32'h7FFFFFFF, 6'h00);
    rdc(`REG_STATUS, 32'h00040402, "status pending");
    op(4'h4, 64'h7FF0000000000000, 1'b0, 1'b0, 3'h1, 64'h7FFFFFFFFFFFFFFF, 6'h20);
    op(4'h0, 32'h7F800000, 32'h3F800000, 1'b0, 3'h3, 32'h7F800000, 6'h00);
    op(4'h0, 32'h00000001, 32'h00000001, 1'b0, 3'h3, 1'b0, 6'h00);
    // Rounding modes
    op(4'h0, 64'h8000008000000000, 1'b0, 17'h0007F, 3'h0, 32'h3F800000, 6'h02);
    op(4'h0, 64'h8000018000000000, 1'b0, 17'h0007F, 3'h0, 32'h3F800002, 6'h02);
    op(4'h2, 64'h8000008000000000, 1'b0, 17'h0007F, 3'h0, 32'h3F800001, 6'h02);
    op(4'h1, 64'h8000018000000000, 1'b0, 17'h1007F, 3'h0, 32'hBF800001, 6'h02);
    op(4'h3, 64'h8000008000000000, 1'b0, 17'h1007F, 3'h0, 32'hBF800001, 6'h02);
    op(4'h0, 64'h8000000000000000, 1'b0, 17'h0007F, 3'h0, 32'h3F800000, 6'h00);
    op(4'h4, 64'h8000000000000400, 1'b0, 17'h003FF, 3'h0, 64'h3FF0000000000000, 6'h02);
    // Overflow, underflow, zero
    op(4'h1, 64'h8000000000000000, 1'b0, 17'h000FF, 3'h0, 32'h7F7FFFFF, 6'h06);
    op(4'h2, 64'h8000000000000000, 1'b0, 17'h000FF, 3'h0, 32'h7F800000, 6'h06);
    op(4'h3, 64'h8000000000000000, 1'b0, 17'h100FF, 3'h0, 32'hFF800000, 6'h06);
    op(4'h2, 64'h8000000000000000, 1'b0, 17'h100FF, 3'h0, 32'hFF7FFFFF, 6'h06);
    op(4'h0, 64'h8000000000000000, 1'b0, 17'h00000, 3'h0, 1'b0, 6'h08);
    op(4'h0, 64'h8000000000000000, 1'b0, 17'h00001, 3'h0, 32'h00800000, 6'h00);
    op(4'h0, 1'b0, 1'b0, 17'h10000, 3'h0, 32'h80000000, 6'h00);
    op(4'h0, 64'h4000000000000000, 1'b0, 17'h0007F, 3'h0, 1'b0, 6'h08);
    // Float to integer
    op(4'h0, 32'h3FC00000, 1'b0, 1'b0, 3'h5, 32'h00000002, 6'h02);
    op(4'h1, 32'h3FC00000, 1'b0, 1'b0, 3'h5, 32'h00000001, 6'h02);
    op(4'h0, 32'h4F000000, 1'b0, 1'b0, 3'h5, 32'h80000000, 6'h04);
    op(4'h0, 32'hBF800000, 1'b0, 1'b0, 3'h5, 32'hFFFFFFFF, 6'h00);
    // Zero divide, interrupt and sticky flags
    wr(`REG_ENABLE, 32'h00000010);
    op(4'h0, 32'h3F800000, 32'h80000000, 1'b0, 3'h2, 32'hFF800000, 6'h10);
    check("irq", 64'h1, {63'h0, fp_irq});
    wr(`REG_CMD, 32'h00000006);
    rdc(`REG_FLAGS, 32'h00000010, "sticky");
    wr(`REG_RESULT_LO, 32'h12345678);
    rdc(`REG_RESULT_LO, 32'h3F800000, "result ro");
    wr(`REG_ENABLE, 32'h0);
    repeat (2) @(posedge i_sys_clk);
    check("irq off", 64'h0, {63'h0, fp_irq});
    wr(`REG_FLAGS, 32'h00000010);
    rdc(`REG_FLAGS, 32'h0, "cleared");
    finish_test;
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    error_cnt++;
    finish_test;
  end
endmodule // fp_round_except_tb

bind fp_round_except fp_round_except_assertions chk (.i_sys_clk(i_sys_clk),
  .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_fp_irq(o_fp_irq));
